/* crc_engine.sv */
// byte-wide crc engine, left-aligned so both 16-bit formats share the 32-bit datapath
`timescale 1ns/1ps
`include "framer_regs.svh"
module crc_engine (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic en,
  input wire logic [7:0] data,
  input wire framer_pkg::crc_sel_t sel,
  output logic [31:0] crc
);
  typedef struct packed {
    logic [31:0] crc;
  } crc_st_t;

  crc_st_t s;
  crc_st_t n;
  logic [31:0] poly;

  // msb-first update over one byte; 16-bit crcs live in the top half
  function automatic logic [31:0] step8(input logic [31:0] c, input logic [7:0] d,
                                        input logic [31:0] p);
    logic [31:0] r;
    int i;
    r = c;
    for (i = 7; i >= 0; i--) begin
      if (r[31] ^ d[i]) r = {r[30:0], 1'b0} ^ p;
      else r = {r[30:0], 1'b0};
    end
    step8 = r;
  endfunction : step8

  // polynomial select, unknown code falls back to the 32-bit format
  always_comb begin
    case (sel)
      framer_pkg::CRC_CCITT: poly = `CRC_POLY_CCITT;
      framer_pkg::CRC_IBM: poly = `CRC_POLY_IBM;
      default: poly = `CRC_POLY_32;
    endcase
  end

  // clear beats en so a packet start always begins from the seed
  always_comb begin
    n = s;
    if (sys_rst || clear) n.crc = 32'h00000000;
    else if (en) n.crc = step8(s.crc, data, poly);
  end

  always_ff @(posedge sys_clk) begin
    s <= n;
  end

  assign crc = s.crc;

  property p_crc_seed;
    @(posedge sys_clk) disable iff (sys_rst) clear |=> crc == 32'h00000000;
  endproperty
  a_crc_seed: assert property (p_crc_seed) else $error("crc not seeded with zero");

  property p_crc_poly;
    @(posedge sys_clk) disable iff (sys_rst)
      en && !clear && s.crc == 32'h00000000 && data == 8'h01 |=> crc == $past(poly);
  endproperty
  a_crc_poly: assert property (p_crc_poly) else $error("crc polynomial wrong");
endmodule : crc_engine

/* framer_pkg.sv */
// types shared by the test packet framer and its crc engine
package framer_pkg;
  typedef enum logic [1:0] {MOD_OOK = 2'h0, MOD_2FSK = 2'h1, MOD_4FSK = 2'h2} mod_t;
  typedef enum logic [2:0] {
    CODE_NRZ = 3'h0, CODE_WHITEN = 3'h1, CODE_MANCH = 3'h2,
    CODE_FEC_RSC = 3'h3, CODE_FEC_NRNSC = 3'h4
  } coding_t;
  typedef enum logic [1:0] {CRC_CCITT = 2'h0, CRC_IBM = 2'h1, CRC_32 = 2'h2} crc_sel_t;
  typedef enum logic [2:0] {
    F_IDLE = 3'h0, F_PRE = 3'h1, F_SYNC = 3'h3, F_PAY = 3'h2, F_CRC = 3'h6
  } frame_t;
  typedef enum logic [1:0] {M_MENU = 2'h0, M_EDIT_SPACE = 2'h1, M_EDIT_CHAN = 2'h3} menu_t;
endpackage : framer_pkg

/* framer_regs.svh */
// register offsets, field positions, reset values and timing for the test packet framer
`ifndef FRAMER_REGS_SVH
`define FRAMER_REGS_SVH
// register offsets on the plain register port
`define REG_CTRL 4'h0
`define REG_PRE_LEN 4'h1
`define REG_PKT_LEN 4'h2
`define REG_SPACING 4'h3
`define REG_CHANNEL 4'h4
`define REG_BASE 4'h5
`define REG_EDIT 4'h6
`define REG_STATUS 4'h7
`define REG_EDIT_VAL 4'h8
`define REG_OFFSET 4'h9
`define REG_FREQ 4'hA
// control register fields
`define CTRL_START 0
`define CTRL_MOD_LSB 1
`define CTRL_CODE_LSB 3
`define CTRL_CRC_LSB 6
// edit register commands
`define EDIT_SPACE_CMD 2'h1
`define EDIT_CHAN_CMD 2'h2
// reset values
`define RST_MOD 2'h1
`define RST_CODE 3'h0
`define RST_CRC 2'h0
`define RST_PRE_LEN 8'h08
`define RST_PKT_LEN 11'h040
`define RST_BASE 32'h00000000
`define RST_RND_SEED 32'h1ACEB00C
// packet contents
`define PRE_2LVL 8'hAA
`define PRE_4FSK 8'hCC
`define SYNC_WORD 48'h2DD42DD42DD4
`define SYNC_BYTES 3'h6
`define PN9_SEED 9'h1FF
`define CRC_POLY_CCITT 32'h10210000
`define CRC_POLY_IBM 32'h80050000
`define CRC_POLY_32 32'h04C11DB7
// timing
`define CLK_PERIOD_NS 10
`define LONG_PRESS_NS 1500000000
`define REPEAT_NS 100000000
`endif

/* fsk_mod_model.sv */
// behavioural modulator at the far side: takes symbols and rebuilds bytes msb first
`timescale 1ns/1ps
module fsk_mod_model (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic four,
  input wire logic tx_valid,
  input wire logic [1:0] tx_sym,
  input wire logic tx_busy,
  output logic tx_ready,
  output logic byte_stb = 1'b0,
  output logic [7:0] byte_val
);
  logic [7:0] sh_r;
  logic [3:0] nb_r = 4'h0;
  logic [1:0] gap_r = 2'h0;
  logic [3:0] nb;
  logic [7:0] nx;
  // slow mode takes one symbol in three cycles, so held symbols get stressed
  assign tx_ready = !slow || gap_r == 2'h2;
  assign nb = nb_r + (four ? 4'h2 : 4'h1);
  assign nx = four ? {sh_r[5:0], tx_sym} : {sh_r[6:0], tx_sym[0]};
  // byte assembly; restarts whenever the framer goes idle
  always @(posedge sys_clk) begin
    gap_r <= gap_r == 2'h2 ? 2'h0 : gap_r + 2'h1;
    byte_stb <= 1'b0;
    if (!tx_busy) begin
      nb_r <= 4'h0;
    end else if (tx_valid && tx_ready) begin
      sh_r <= nx;
      nb_r <= nb == 4'h8 ? 4'h0 : nb;
      byte_stb <= nb == 4'h8;
      byte_val <= nx;
    end
  end
endmodule : fsk_mod_model

/* test_packet_framer.sv */
// test packet framer with channel spacing and channel editing from push keys
//
// How it works
// - payload length comes from the packet length register, never from the packet.
// - preamble byte is AA for OOK and 2FSK, CC for 4FSK.
// - six-byte sync word 2DD42DD42DD4 follows the preamble.
// - crc formats CCITT-16, IBM-16 and 32-bit 04C11DB7, one selected.
// - crc starts from zero seed every packet.
// - coding applies to payload and crc; preamble stays uncoded.
// - manchester coding also covers the sync word.
// - 4FSK dibits 00,01,10,11 map to -full,-third,+third,+full deviation.
// - payload holds fresh random bytes, packet length of them.
// - channel spacing is 0 to 255 kHz.
// - channel index is 0 to 255.
// - offset is spacing times index in kHz, added to base frequency.
// - down arrow press adds one, 255 wraps to 0.
// - up arrow press subtracts one, 0 wraps to 255.
// - holding an arrow about 1.5 s auto-repeats steps until release.
// - either confirm key commits edited value and returns to menu.
// - whitening uses PN9 with seed 1FF.
`timescale 1ns/1ps
`include "framer_regs.svh"
module test_packet_framer #(
  parameter logic [27:0] LONG_CYC = 28'((`LONG_PRESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS),
  parameter logic [27:0] REPEAT_CYC = 28'(`REPEAT_NS / `CLK_PERIOD_NS)
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic down_arrow_key,
  input wire logic up_arrow_key,
  input wire logic confirm_key_a,
  input wire logic confirm_key_b,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [1:0] tx_sym,
  output logic [2:0] tx_level,
  output logic tx_busy,
  output logic [15:0] freq_offset_khz,
  output logic [31:0] op_freq_khz
);
  typedef struct packed {
    framer_pkg::mod_t mod;
    framer_pkg::coding_t coding;
    framer_pkg::crc_sel_t crc_sel;
    logic [7:0] pre_len;
    logic [10:0] pkt_len;
    logic [7:0] spacing;
    logic [7:0] channel;
    logic [31:0] base_khz;
    framer_pkg::menu_t menu;
    logic [7:0] edit_val;
    logic [3:0] key_s1;
    logic [3:0] key_s2;
    logic [3:0] key_d;
    logic [27:0] hold_cnt;
    logic [27:0] rep_cnt;
    framer_pkg::frame_t fst;
    logic [10:0] idx;
    logic [15:0] sh;
    logic [4:0] cnt;
    logic [8:0] pn;
    logic [31:0] rnd;
    logic [15:0] pkt_cnt;
    logic busy;
    logic tx_valid;
    logic [1:0] tx_sym;
    logic [2:0] tx_level;
    logic [31:0] rdata;
    logic [15:0] offset;
    logic [31:0] freq;
  } st_t;

  st_t s;
  st_t n;
  logic start_pkt;
  logic byte_ld;
  logic [7:0] byte_v;
  logic crc_en;
  logic [31:0] crc_val;
  logic sw2;
  logic manch;
  logic whit;
  logic [3:0] edge_k;
  logic held;
  logic rep_fire;
  logic step_inc;
  logic step_dec;
  logic confirm;
  logic edit_req;

  // pn9 whitening of one byte, lsb first; returns {next state, coded byte}
  function automatic logic [16:0] whiten(input logic [7:0] b, input logic [8:0] p);
    logic [8:0] q;
    logic [7:0] o;
    int i;
    q = p;
    o = b;
    for (i = 0; i < 8; i++) begin
      o[i] = b[i] ^ q[0];
      q = {q[0] ^ q[5], q[8:1]};
    end
    whiten = {q, o};
  endfunction : whiten

  // manchester: one becomes 01, zero becomes 10, msb first
  function automatic logic [15:0] manch16(input logic [7:0] b);
    logic [15:0] m;
    int i;
    m = 16'h0000;
    for (i = 0; i < 8; i++) begin
      m[2*i+1 -: 2] = {~b[i], b[i]};
    end
    manch16 = m;
  endfunction : manch16

  // deviation level in thirds of peak_deviation, signed 3-bit
  function automatic logic [2:0] level(input logic [1:0] sym, input logic four);
    logic [2:0] l;
    if (!four) begin
      l = sym[0] ? 3'h3 : 3'h5;
    end else begin
      case (sym)
        2'b00: l = 3'h5;
        2'b01: l = 3'h7;
        2'b10: l = 3'h1;
        default: l = 3'h3;
      endcase
    end
    level = l;
  endfunction : level

  crc_engine u_crc (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clear(start_pkt),
    .en(crc_en),
    .data(byte_v),
    .sel(s.crc_sel),
    .crc(crc_val)
  );

  // next-state logic for the whole block
  always_comb begin
    logic [31:0] rnd_t;
    logic [16:0] wh;
    logic [7:0] code_b;
    logic man_on;
    rnd_t = s.rnd;
    wh = 17'h00000;
    code_b = 8'h00;
    man_on = 1'b0;
    n = s;
    start_pkt = 1'b0;
    byte_ld = 1'b0;
    byte_v = 8'h00;
    crc_en = 1'b0;
    rep_fire = 1'b0;
    sw2 = (s.mod == framer_pkg::MOD_4FSK);
    manch = (s.coding == framer_pkg::CODE_MANCH);
    whit = (s.coding == framer_pkg::CODE_WHITEN);
    edge_k = s.key_s2 & ~s.key_d;
    held = s.key_s2[0] ^ s.key_s2[1];
    edit_req = reg_wr && (reg_addr == `REG_EDIT);

    // free-running xorshift, so every payload byte is fresh
    rnd_t = rnd_t ^ {rnd_t[18:0], 13'h0000};
    rnd_t = rnd_t ^ {17'h00000, rnd_t[31:17]};
    rnd_t = rnd_t ^ {rnd_t[26:0], 5'h00};
    n.rnd = rnd_t;

    // key pins pass two flops; edges only look at the second stage
    n.key_s1 = {confirm_key_b, confirm_key_a, up_arrow_key, down_arrow_key};
    n.key_s2 = s.key_s1;
    n.key_d = s.key_s2;

    // long press: hold timer, then a repeat tick; both arrows held does nothing
    if (!held) begin
      n.hold_cnt = 28'h0000000;
      n.rep_cnt = 28'h0000000;
    end else if (s.hold_cnt < LONG_CYC) begin
      n.hold_cnt = s.hold_cnt + 28'h0000001;
    end else if (s.rep_cnt >= REPEAT_CYC - 28'h0000001) begin
      n.rep_cnt = 28'h0000000;
      rep_fire = 1'b1;
    end else begin
      n.rep_cnt = s.rep_cnt + 28'h0000001;
    end
    step_inc = edge_k[0] | (rep_fire & s.key_s2[0]);
    step_dec = edge_k[1] | (rep_fire & s.key_s2[1]);
    confirm = |edge_k[3:2];

    // register writes; the control register (modulation, coding, crc) is frozen while a packet is in flight
    if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: begin
          if (!s.busy) begin
            n.mod = framer_pkg::mod_t'(reg_wdata[`CTRL_MOD_LSB +: 2]);
            n.coding = framer_pkg::coding_t'(reg_wdata[`CTRL_CODE_LSB +: 3]);
            n.crc_sel = framer_pkg::crc_sel_t'(reg_wdata[`CTRL_CRC_LSB +: 2]);
            start_pkt = reg_wdata[`CTRL_START];
          end
        end
        `REG_PRE_LEN: n.pre_len = reg_wdata[7:0];
        `REG_PKT_LEN: n.pkt_len = reg_wdata[10:0];
        `REG_SPACING: n.spacing = reg_wdata[7:0];
        `REG_CHANNEL: n.channel = reg_wdata[7:0];
        `REG_BASE: n.base_khz = reg_wdata;
        default: n.base_khz = s.base_khz;
      endcase
    end

    // menu: edit a working copy, commit on confirm
    case (s.menu)
      framer_pkg::M_MENU: begin
        if (edit_req && reg_wdata[1:0] == `EDIT_SPACE_CMD) begin
          n.menu = framer_pkg::M_EDIT_SPACE;
          n.edit_val = s.spacing;
        end else if (edit_req && reg_wdata[1:0] == `EDIT_CHAN_CMD) begin
          n.menu = framer_pkg::M_EDIT_CHAN;
          n.edit_val = s.channel;
        end
      end
      framer_pkg::M_EDIT_SPACE, framer_pkg::M_EDIT_CHAN: begin
        if (step_inc && !step_dec) n.edit_val = s.edit_val + 8'h01;
        else if (step_dec && !step_inc) n.edit_val = s.edit_val - 8'h01;
        if (confirm) begin
          if (s.menu == framer_pkg::M_EDIT_SPACE) n.spacing = s.edit_val;
          else n.channel = s.edit_val;
          n.menu = framer_pkg::M_MENU;
        end
      end
      default: n.menu = framer_pkg::M_MENU;
    endcase

    // two-stage frequency pipeline keeps the multiplier off the bus path
    n.offset = 16'(s.spacing) * 16'(s.channel);
    n.freq = s.base_khz + {16'h0000, s.offset};

    // output stage: one bit per symbol, or a dibit in 4FSK
    if (!s.tx_valid || tx_ready) begin
      if (s.cnt >= (sw2 ? 5'h02 : 5'h01)) begin
        n.tx_valid = 1'b1;
        n.tx_sym = sw2 ? s.sh[15:14] : {1'b0, s.sh[15]};
        n.tx_level = level(sw2 ? s.sh[15:14] : {1'b0, s.sh[15]}, sw2);
        n.sh = sw2 ? {s.sh[13:0], 2'b00} : {s.sh[14:0], 1'b0};
        n.cnt = s.cnt - (sw2 ? 5'h02 : 5'h01);
      end else begin
        n.tx_valid = 1'b0;
      end
    end

    // byte engine: next field byte enters once the shifter is empty
    if (s.cnt == 5'h00) begin
      case (s.fst)
        framer_pkg::F_PRE: begin
          byte_ld = 1'b1;
          byte_v = sw2 ? `PRE_4FSK : `PRE_2LVL;
          n.idx = s.idx + 11'h001;
          if (s.idx + 11'h001 == {3'h0, s.pre_len}) begin
            n.fst = framer_pkg::F_SYNC;
            n.idx = 11'h000;
          end
        end
        framer_pkg::F_SYNC: begin
          byte_ld = 1'b1;
          byte_v = 8'(`SYNC_WORD >> {3'h5 - s.idx[2:0], 3'h0});
          n.idx = s.idx + 11'h001;
          if (s.idx[2:0] == `SYNC_BYTES - 3'h1) begin
            n.fst = (s.pkt_len == 11'h000) ? framer_pkg::F_CRC : framer_pkg::F_PAY;
            n.idx = 11'h000;
          end
        end
        framer_pkg::F_PAY: begin
          byte_ld = 1'b1;
          byte_v = s.rnd[7:0];
          crc_en = 1'b1;
          n.idx = s.idx + 11'h001;
          if (s.idx + 11'h001 == s.pkt_len) begin
            n.fst = framer_pkg::F_CRC;
            n.idx = 11'h000;
          end
        end
        framer_pkg::F_CRC: begin
          byte_ld = 1'b1;
          byte_v = 8'(crc_val >> {2'h3 - s.idx[1:0], 3'h0});
          n.idx = s.idx + 11'h001;
          if (s.idx[1:0] == (s.crc_sel[1] ? 2'h3 : 2'h1)) begin // codes 2 and 3 are 32-bit
            n.fst = framer_pkg::F_IDLE;
            n.idx = 11'h000;
            n.pkt_cnt = s.pkt_cnt + 16'h0001;
          end
        end
        default: byte_ld = 1'b0;
      endcase
    end

    // line coding; crc is taken on the raw payload above
    code_b = byte_v;
    if (byte_ld && whit && (s.fst == framer_pkg::F_PAY || s.fst == framer_pkg::F_CRC)) begin
      wh = whiten(byte_v, s.pn);
      n.pn = wh[16:8];
      code_b = wh[7:0];
    end
    man_on = manch && (s.fst != framer_pkg::F_PRE);
    if (byte_ld) begin
      n.sh = man_on ? manch16(code_b) : {code_b, 8'h00};
      n.cnt = man_on ? 5'h10 : 5'h08;
    end

    // start a packet; an empty preamble goes straight to the sync word
    if (start_pkt) begin
      n.fst = (s.pre_len == 8'h00) ? framer_pkg::F_SYNC : framer_pkg::F_PRE;
      n.idx = 11'h000;
      n.pn = `PN9_SEED;
    end
    n.busy = (n.fst != framer_pkg::F_IDLE) || (n.cnt != 5'h00) || n.tx_valid;

    // read data stand for one cycle only; unmapped reads return zero
    n.rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: n.rdata = {24'h000000, s.crc_sel, s.coding, s.mod, 1'b0};
        `REG_PRE_LEN: n.rdata = {24'h000000, s.pre_len};
        `REG_PKT_LEN: n.rdata = {21'h000000, s.pkt_len};
        `REG_SPACING: n.rdata = {24'h000000, s.spacing};
        `REG_CHANNEL: n.rdata = {24'h000000, s.channel};
        `REG_BASE: n.rdata = s.base_khz;
        `REG_EDIT: n.rdata = {30'h00000000, s.menu};
        `REG_STATUS: n.rdata = {s.pkt_cnt, 13'h0000, s.menu, s.busy};
        `REG_EDIT_VAL: n.rdata = {24'h000000, s.edit_val};
        `REG_OFFSET: n.rdata = {16'h0000, s.offset};
        `REG_FREQ: n.rdata = s.freq;
        default: n.rdata = 32'h00000000;
      endcase
    end

    // synchronous reset to documented defaults
    if (sys_rst) begin
      n = '0;
      n.mod = framer_pkg::mod_t'(`RST_MOD);
      n.coding = framer_pkg::coding_t'(`RST_CODE);
      n.crc_sel = framer_pkg::crc_sel_t'(`RST_CRC);
      n.pre_len = `RST_PRE_LEN;
      n.pkt_len = `RST_PKT_LEN;
      n.base_khz = `RST_BASE;
      n.pn = `PN9_SEED;
      n.rnd = `RST_RND_SEED;
    end
  end

  always_ff @(posedge sys_clk) begin
    s <= n;
  end

  assign reg_rdata = s.rdata;
  assign tx_valid = s.tx_valid;
  assign tx_sym = s.tx_sym;
  assign tx_level = s.tx_level;
  assign tx_busy = s.busy;
  assign freq_offset_khz = s.offset;
  assign op_freq_khz = s.freq;

  property p_fixed_len;
    @(posedge sys_clk) disable iff (sys_rst)
      s.fst == framer_pkg::F_PAY && byte_ld && s.idx + 11'h001 == s.pkt_len |=>
      s.fst == framer_pkg::F_CRC;
  endproperty
  a_fixed_len: assert property (p_fixed_len) else $error("payload length wrong");

  property p_pre_count;
    @(posedge sys_clk) disable iff (sys_rst)
      s.fst == framer_pkg::F_PRE && byte_ld && s.idx + 11'h001 == {3'h0, s.pre_len} |=>
      s.fst == framer_pkg::F_SYNC && s.idx == 11'h000;
  endproperty
  a_pre_count: assert property (p_pre_count) else $error("preamble count wrong");

  property p_pre_byte;
    @(posedge sys_clk) disable iff (sys_rst)
      s.fst == framer_pkg::F_PRE && byte_ld |-> byte_v == (sw2 ? 8'hCC : 8'hAA) ##1 s.cnt == 5'h08;
  endproperty
  a_pre_byte: assert property (p_pre_byte) else $error("preamble byte wrong");

  property p_sync_first;
    @(posedge sys_clk) disable iff (sys_rst)
      s.fst == framer_pkg::F_SYNC && byte_ld && s.idx == 11'h000 |-> byte_v == 8'h2D;
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("sync word wrong");

  property p_manch_sync;
    @(posedge sys_clk) disable iff (sys_rst)
      s.fst == framer_pkg::F_SYNC && byte_ld && manch |=> s.cnt == 5'h10;
  endproperty
  a_manch_sync: assert property (p_manch_sync) else $error("sync not manchester");

  property p_map_4fsk;
    @(posedge sys_clk) disable iff (sys_rst)
      s.tx_valid && sw2 |-> s.tx_level == {~s.tx_sym[1], s.tx_sym[0], 1'b1};
  endproperty
  a_map_4fsk: assert property (p_map_4fsk) else $error("4fsk mapping wrong");

  property p_fresh_rnd;
    @(posedge sys_clk) disable iff (sys_rst) byte_ld && crc_en |=> s.rnd != $past(s.rnd);
  endproperty
  a_fresh_rnd: assert property (p_fresh_rnd) else $error("random source stuck");

  property p_freq;
    @(posedge sys_clk) disable iff (sys_rst)
      !$past(sys_rst) && !$past(sys_rst, 2) |->
      s.freq == $past(s.base_khz) + {16'h0000, 16'($past(s.spacing, 2)) * 16'($past(s.channel, 2))};
  endproperty
  a_freq: assert property (p_freq) else $error("operating frequency wrong");

  property p_wrap_up;
    @(posedge sys_clk) disable iff (sys_rst)
      s.menu != framer_pkg::M_MENU && step_inc && !step_dec && s.edit_val == 8'hFF |=>
      s.edit_val == 8'h00;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("increment wrap wrong");

  property p_wrap_down;
    @(posedge sys_clk) disable iff (sys_rst)
      s.menu != framer_pkg::M_MENU && step_dec && !step_inc && s.edit_val == 8'h00 |=>
      s.edit_val == 8'hFF;
  endproperty
  a_wrap_down: assert property (p_wrap_down) else $error("decrement wrap wrong");

  property p_repeat;
    @(posedge sys_clk) disable iff (sys_rst)
      held && s.hold_cnt == LONG_CYC && s.rep_cnt == REPEAT_CYC - 28'h0000001
      |-> (s.key_s2[0] ? step_inc : step_dec);
  endproperty
  a_repeat: assert property (p_repeat) else $error("auto repeat missing");

  property p_confirm;
    @(posedge sys_clk) disable iff (sys_rst)
      confirm && s.menu == framer_pkg::M_EDIT_SPACE |=>
      s.menu == framer_pkg::M_MENU && s.spacing == $past(s.edit_val);
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirm did not commit");

  property p_pn_seed;
    @(posedge sys_clk) disable iff (sys_rst) start_pkt |=> s.pn == 9'h1FF;
  endproperty
  a_pn_seed: assert property (p_pn_seed) else $error("whitening seed wrong");

  property p_order;
    @(posedge sys_clk) disable iff (sys_rst)
      s.fst == framer_pkg::F_PAY |=> s.fst == framer_pkg::F_PAY || s.fst == framer_pkg::F_CRC;
  endproperty
  a_order: assert property (p_order) else $error("field order wrong");
endmodule : test_packet_framer

/* test_packet_framer_tb.sv */
// self-checking bench for the test packet framer
`timescale 1ns/1ps
`include "framer_regs.svh"
module test_packet_framer_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] keys = 4'h0;
  logic slow = 1'b0;
  logic four = 1'b0;
  logic [31:0] reg_rdata, op_freq_khz, rv, ev;
  logic [23:0] prev = 24'h0;
  logic [15:0] freq_offset_khz;
  logic [2:0] tx_level;
  logic [1:0] tx_sym;
  logic tx_ready, tx_valid, tx_busy, byte_stb;
  logic [7:0] byte_val;
  logic [7:0] q[$];
  logic [3:0] ra[6] = '{`REG_CTRL, `REG_PRE_LEN, `REG_PKT_LEN, `REG_SPACING, `REG_STATUS, 4'hF};
  logic [31:0] re[6] = '{32'h2, 32'h8, 32'h40, 32'h0, 32'h0, 32'h0};
  int n_fail = 0;
  int checks_done = 0;
  int k;
  always #5 sys_clk = ~sys_clk;
  test_packet_framer #(.LONG_CYC(28'h14), .REPEAT_CYC(28'h4)) dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .down_arrow_key(keys[0]), .up_arrow_key(keys[1]),
    .confirm_key_a(keys[2]), .confirm_key_b(keys[3]), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_sym(tx_sym), .tx_level(tx_level), .tx_busy(tx_busy),
    .freq_offset_khz(freq_offset_khz), .op_freq_khz(op_freq_khz));
  fsk_mod_model tx (.sys_clk(sys_clk), .slow(slow), .four(four), .tx_valid(tx_valid),
    .tx_sym(tx_sym), .tx_busy(tx_busy), .tx_ready(tx_ready), .byte_stb(byte_stb),
    .byte_val(byte_val));
  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  task automatic key(input int which, input int cyc);
    @(posedge sys_clk);
    keys <= 4'h1 << which;
    repeat (cyc) @(posedge sys_clk);
    keys <= 4'h0;
    repeat (8) @(posedge sys_clk);
  endtask : key
  function automatic logic [15:0] man(input logic [7:0] x);
    for (int i = 0; i < 8; i++) man[2 * i +: 2] = x[i] ? 2'h1 : 2'h2;
  endfunction : man
  function automatic logic [31:0] lvl(input logic [1:0] s);
    return s[1] ? (s[0] ? 32'h3 : 32'h1) : (s[0] ? 32'h7 : 32'h5);
  endfunction : lvl
  // collect bytes rebuilt by the model; check 4-level deviation of every symbol taken
  always @(posedge sys_clk) begin
    if (byte_stb) q.push_back(byte_val);
    if (!sys_rst && four && tx_valid && tx_ready) cmp("level", lvl(tx_sym), tx_level);
  end
  // one packet: send, wait bounded, then check framing, coding and crc
  task automatic pkt(input logic [7:0] ctrl, input logic [7:0] pre, input int np, input bit mc,
                     input int pl, input int cw, input logic [31:0] poly, input bit poke);
    logic [7:0] lg[$];
    logic [15:0] w;
    logic [7:0] x;
    logic [31:0] c;
    logic [47:0] sw;
    int nl;
    sw = `SYNC_WORD;
    nl = 6 + pl + cw / 8;
    wr(`REG_PRE_LEN, np);
    wr(`REG_PKT_LEN, pl);
    q.delete();
    four = ctrl[2:1] == 2'h2;
    wr(`REG_CTRL, ctrl);
    for (k = 0; k < 9 && !tx_busy; k++) @(negedge sys_clk);
    cmp("busy", 32'h1, tx_busy);
    if (poke) wr(`REG_CTRL, 32'h5);
    for (k = 0; k < 30000 && tx_busy; k++) @(negedge sys_clk);
    if (k == 30000) begin
      n_fail++;
      test_done();
    end
    repeat (3) @(posedge sys_clk);
    cmp("byte count", np + (mc ? 2 * nl : nl), q.size());
    if (q.size() != np + (mc ? 2 * nl : nl)) return;
    for (k = 0; k < np; k++) cmp("preamble", pre, q[k]);
    for (k = 0; k < nl; k++) begin
      x = q[np + k];
      if (mc) begin
        w = {q[np + 2 * k], q[np + 2 * k + 1]};
        for (int b = 0; b < 8; b++) x[b] = w[2 * b];
        cmp("manchester", man(x), w);
      end
      lg.push_back(x);
    end
    for (k = 0; k < 6; k++) cmp("sync", sw[47 - 8 * k -: 8], lg[k]);
    c = 32'h0;
    for (k = 0; k < pl; k++) begin
      c = c ^ {lg[6 + k], 24'h0};
      repeat (8) c = c[31] ? (c << 1) ^ poly : c << 1;
    end
    for (k = 0; k < cw / 8 && poly != 0; k++) cmp("crc", c[31 - 8 * k -: 8], lg[6 + pl + k]);
    if (poly == 0) cmp("whiten", 32'hFFE1, {lg[6 + pl], lg[7 + pl]});
    if (pl >= 3) begin
      cmp("fresh payload", 1, {lg[6], lg[7], lg[8]} !== prev);
      prev = {lg[6], lg[7], lg[8]};
    end
  endtask : pkt
  // main sequence: defaults, frequency, packets in every mode, then key editing
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      cmp("reset value", re[i], rv);
    end
    wr(`REG_SPACING, 32'h1FF);
    wr(`REG_CHANNEL, 32'hFF);
    wr(`REG_BASE, 32'h69B68);
    rd(`REG_SPACING);
    cmp("spacing", 32'hFF, rv);
    rd(`REG_OFFSET);
    cmp("offset", 32'hFE01, rv);
    rd(`REG_FREQ);
    cmp("freq", 32'h79969, rv);
    cmp("offset pin", 32'hFE01, freq_offset_khz);
    cmp("freq pin", 32'h79969, op_freq_khz);
    rd(`REG_CHANNEL);
    cmp("channel", 32'hFF, rv);
    pkt(8'h03, 8'hAA, 2, 0, 3, 16, `CRC_POLY_CCITT, 1);
    rd(`REG_CTRL);
    cmp("ctrl kept", 32'h2, rv);
    pkt(8'h03, 8'hAA, 2, 0, 3, 16, `CRC_POLY_CCITT, 0);
    slow <= 1'b1;
    pkt(8'h85, 8'hCC, 1, 0, 20, 32, `CRC_POLY_32, 0);
    slow <= 1'b0;
    pkt(8'h51, 8'hAA, 1, 1, 2, 16, `CRC_POLY_IBM, 0);
    pkt(8'h03, 8'hAA, 0, 0, 0, 16, `CRC_POLY_CCITT, 0);
    pkt(8'h0B, 8'hAA, 0, 0, 0, 16, 32'h0, 0);
    rd(`REG_STATUS);
    cmp("packet count", 32'h6, rv[31:16]);
    wr(`REG_EDIT, `EDIT_SPACE_CMD);
    key(0, 5);
    rd(`REG_EDIT_VAL);
    cmp("down wrap", 32'h0, rv);
    key(2, 5);
    rd(`REG_SPACING);
    cmp("commit a", 32'h0, rv);
    rd(`REG_STATUS);
    cmp("menu", 32'h0, rv[2:1]);
    wr(`REG_CHANNEL, 32'h0);
    wr(`REG_EDIT, `EDIT_CHAN_CMD);
    key(1, 5);
    rd(`REG_EDIT_VAL);
    cmp("up wrap", 32'hFF, rv);
    key(1, 40);
    rd(`REG_EDIT_VAL);
    ev = rv;
    cmp("repeat", 1, 32'hFF - ev >= 2 && 32'hFF - ev <= 10);
    key(3, 5);
    rd(`REG_CHANNEL);
    cmp("commit b", ev, rv);
    test_done();
  end
endmodule : test_packet_framer_tb
